// File: logic/tmr_cfg.svh
// Register indices, field positions, reset values and fixed tops of the compare-output timer.
// Byte address of a register is four times its index on a 32-bit APB bus.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define IDX_CTRL_FIRST 10'h080
`define IDX_CTRL_SECOND 10'h081
`define IDX_TICK_CTRL 10'h082
`define IDX_COUNTER 10'h084
`define IDX_CAPTURE 10'h086
`define IDX_CMP_A 10'h088
`define IDX_CMP_B 10'h08A
`define IDX_PORT 10'h08C
`define IDX_INT_STATUS 10'h090
`define IDX_INT_ENABLE 10'h091
`define IDX_INT_CLEAR 10'h092

`define CHA_MODE_HI 7
`define CHA_MODE_LO 6
`define CHB_MODE_HI 5
`define CHB_MODE_LO 4
`define WGM_LO_HI 1
`define WGM_LO_LO 0
`define WGM_HI_HI 4
`define WGM_HI_LO 3
`define TICK_RUN_BIT 8
`define PORT_A_VAL 0
`define PORT_B_VAL 1
`define PORT_A_DIR 2
`define PORT_B_DIR 3
`define ST_MATCH_A 0
`define ST_MATCH_B 1
`define ST_OVERFLOW 2

`define CTRL_RST 8'h00
`define TICK_DIV_RST 8'h00
`define CNT_RST 16'h0000
`define PORT_RST 4'h0
`define INT_RST 3'h0
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF

`endif

// File: logic/tmr_pkg.sv
// Types shared by the compare-output timer modules.
// Assumes tmr_cfg.svh supplies all numeric constants.
package tmr_pkg;

	typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} count_dir_t;

	typedef enum logic [3:0] {
		KIND_NORMAL = 4'b0001,
		KIND_CTC = 4'b0010,
		KIND_FAST = 4'b0100,
		KIND_DUAL = 4'b1000
	} wave_kind_t;

	typedef enum logic [2:0] {UPD_NOW = 3'b001, UPD_TOP = 3'b010, UPD_BOTTOM = 3'b100} upd_point_t;

	typedef enum logic [2:0] {OVF_MAX = 3'b001, OVF_TOP = 3'b010, OVF_BOTTOM = 3'b100} ovf_point_t;

	typedef logic [1:0] out_mode_t;

endpackage

// File: logic/wave_channel.sv
// One compare channel: the output latch and its reaction to match, BOTTOM and direction.
// Assumes tick_en is a one-cycle pulse on pclk and counter_value is the pre-step count.
`timescale 1ns/10ps
`include "tmr_cfg.svh"

module wave_channel
	import tmr_pkg::*;
(
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic tick_en, // Timer step enable
	input wire wave_kind_t kind, // Decoded waveform type
	input wire out_mode_t out_mode, // Output-mode field of this channel
	input wire logic toggle_ok, // Mode value 1 may toggle this channel
	input wire logic counting_up, // Counter direction
	input wire logic [15:0] counter_value, // Current count
	input wire logic [15:0] compare_value, // Active compare value
	input wire logic [15:0] top_value, // Current TOP
	output logic wave_level, // Output latch
	output logic connected // Waveform owns the pin
);

	logic match;
	logic at_bottom;
	logic cmp_top;
	logic cmp_bot;

	assign match = tick_en && (counter_value == compare_value);
	assign at_bottom = tick_en && (counter_value == `CNT_BOTTOM);
	assign cmp_top = (compare_value == top_value);
	assign cmp_bot = (compare_value == `CNT_BOTTOM);

	// Value 1 only counts as connected where it really toggles
	assign connected = out_mode[1] | (out_mode[0] & toggle_ok);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wave_level <= 1'b0;
		end
		else
		begin
			case (kind)
				KIND_NORMAL, KIND_CTC:
				begin
					if (match)
					begin
						case (out_mode)
							2'b01: wave_level <= ~wave_level;
							2'b10: wave_level <= 1'b0;
							2'b11: wave_level <= 1'b1;
							default: wave_level <= wave_level;
						endcase
					end
				end
				KIND_FAST:
				begin
					if (out_mode[1])
					begin
						// Match wins over BOTTOM so a zero compare keeps the level steady
						if (match && !cmp_top)
							wave_level <= out_mode[0];
						else if (at_bottom)
							wave_level <= ~out_mode[0];
					end
					else if (out_mode[0] && toggle_ok && match)
						wave_level <= ~wave_level;
				end
				KIND_DUAL:
				begin
					if (out_mode[1] && match)
					begin
						if (cmp_bot)
							wave_level <= out_mode[0];
						else if (cmp_top)
							wave_level <= ~out_mode[0];
						else if (counting_up)
							wave_level <= out_mode[0];
						else
							wave_level <= ~out_mode[0];
					end
					else if (out_mode == 2'b01 && toggle_ok && match)
						wave_level <= ~wave_level;
				end
				default: wave_level <= wave_level;
			endcase
		end
	end

	AST_START_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !wave_level)
		else $error("latch not low after reset");

	AST_NONPWM_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(kind == KIND_NORMAL || kind == KIND_CTC) && match && out_mode == 2'b10 |=> !wave_level)
		else $error("clear on match failed");

	AST_FAST_BOTTOM_SET: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_FAST && out_mode == 2'b10 && at_bottom && !match |=> wave_level)
		else $error("fast pwm bottom set failed");

	AST_FAST_TOP_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_FAST && out_mode[1] && match && cmp_top && !at_bottom
		|=> wave_level == $past(wave_level))
		else $error("match at top not ignored");

	AST_DUAL_UP_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_DUAL && out_mode == 2'b10 && match && !cmp_top && !cmp_bot
		|=> wave_level == !$past(counting_up))
		else $error("dual slope direction level wrong");

	AST_DUAL_EXTREME: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_DUAL && out_mode[1] && match && cmp_bot |=> wave_level == $past(out_mode[0]))
		else $error("dual slope bottom extreme wrong");

endmodule

// File: logic/timer_wave_top.sv
// Compare-output timer with two channels behind an APB slave.
// Assumes one clock pclk; all APB inputs are on pclk, pins only leave the block.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "tmr_cfg.svh"

module timer_wave_top
	import tmr_pkg::*;
(
	input wire logic pclk, // Bus and timer clock
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] paddr, // APB byte address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic channel_a_wave_out, // Pin A level
	output logic channel_a_wave_oe, // Pin A driver enable
	output logic channel_b_wave_out, // Pin B level
	output logic channel_b_wave_oe, // Pin B driver enable
	output logic irq // Level interrupt
);

	logic [7:0] ctrl_first_q;
	logic [7:0] ctrl_second_q;
	logic [7:0] tick_div_q;
	logic tick_run_q;
	logic [7:0] tick_cnt_q;
	logic tick_en;
	logic [15:0] counter_q;
	count_dir_t dir_q;
	logic [15:0] capture_q;
	logic [15:0] cmp_buf_a_q;
	logic [15:0] cmp_buf_b_q;
	logic [15:0] cmp_act_a_q;
	logic [15:0] cmp_act_b_q;
	logic [3:0] port_q;
	logic [2:0] status_q;
	logic [2:0] status_d;
	logic [2:0] int_en_q;
	logic [2:0] set_ev;
	logic [2:0] clr_ev;
	logic [31:0] prdata_q;
	logic [3:0] waveform_mode_code;
	wave_kind_t kind;
	upd_point_t upd;
	ovf_point_t ovf;
	logic [15:0] top_value;
	logic tog_ok_a;
	logic tog_ok_b;
	logic at_top;
	logic at_bottom;
	logic do_update;
	logic [1:0] ch_level;
	logic [1:0] ch_conn;
	logic [9:0] idx;
	logic hit;
	logic wr_en;
	logic rd_setup;
	out_mode_t channel_a_output_mode;
	out_mode_t channel_b_output_mode;

	// APB decode: zero-wait slave, read data sampled in the setup cycle
	assign idx = paddr[11:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_q;

	always_comb
	begin
		case (idx)
			`IDX_CTRL_FIRST, `IDX_CTRL_SECOND, `IDX_TICK_CTRL, `IDX_COUNTER, `IDX_CAPTURE,
			`IDX_CMP_A, `IDX_CMP_B, `IDX_PORT, `IDX_INT_STATUS, `IDX_INT_ENABLE,
			`IDX_INT_CLEAR: hit = (paddr[1:0] == 2'b00);
			default: hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup)
		begin
			case (idx)
				`IDX_CTRL_FIRST: prdata_q <= {24'h00_0000, ctrl_first_q};
				`IDX_CTRL_SECOND: prdata_q <= {24'h00_0000, ctrl_second_q};
				`IDX_TICK_CTRL: prdata_q <= {23'h00_0000, tick_run_q, tick_div_q};
				`IDX_COUNTER: prdata_q <= {16'h0000, counter_q};
				`IDX_CAPTURE: prdata_q <= {16'h0000, capture_q};
				`IDX_CMP_A: prdata_q <= {16'h0000, cmp_buf_a_q};
				`IDX_CMP_B: prdata_q <= {16'h0000, cmp_buf_b_q};
				`IDX_PORT: prdata_q <= {28'h000_0000, port_q};
				`IDX_INT_STATUS: prdata_q <= {29'h0000_0000, status_q};
				`IDX_INT_ENABLE: prdata_q <= {29'h0000_0000, int_en_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Control registers; unused bits are never stored so they read as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_first_q <= `CTRL_RST;
			ctrl_second_q <= `CTRL_RST;
		end
		else if (wr_en && idx == `IDX_CTRL_FIRST && hit)
			ctrl_first_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
		else if (wr_en && idx == `IDX_CTRL_SECOND && hit)
			ctrl_second_q <= {3'b000, pwdata[`WGM_HI_HI:`WGM_HI_LO], 3'b000};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_div_q <= `TICK_DIV_RST;
			tick_run_q <= 1'b0;
		end
		else if (wr_en && idx == `IDX_TICK_CTRL && hit)
		begin
			tick_div_q <= pwdata[7:0];
			tick_run_q <= pwdata[`TICK_RUN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			capture_q <= `CNT_RST;
			cmp_buf_a_q <= `CNT_RST;
			cmp_buf_b_q <= `CNT_RST;
			port_q <= `PORT_RST;
			int_en_q <= `INT_RST;
		end
		else if (wr_en && hit)
		begin
			case (idx)
				`IDX_CAPTURE: capture_q <= pwdata[15:0];
				`IDX_CMP_A: cmp_buf_a_q <= pwdata[15:0];
				`IDX_CMP_B: cmp_buf_b_q <= pwdata[15:0];
				`IDX_PORT: port_q <= pwdata[3:0];
				`IDX_INT_ENABLE: int_en_q <= pwdata[2:0];
				default: port_q <= port_q;
			endcase
		end
	end

	// Timer tick: a divided enable, never a second clock
	assign tick_en = tick_run_q && (tick_cnt_q == 8'h00);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= 8'h00;
		else if (!tick_run_q || tick_cnt_q == 8'h00)
			tick_cnt_q <= tick_div_q;
		else
			tick_cnt_q <= tick_cnt_q - 8'h01;
	end

	// Mode decode
	assign channel_a_output_mode = ctrl_first_q[`CHA_MODE_HI:`CHA_MODE_LO];
	assign channel_b_output_mode = ctrl_first_q[`CHB_MODE_HI:`CHB_MODE_LO];
	assign waveform_mode_code = {ctrl_second_q[`WGM_HI_HI:`WGM_HI_LO],
		ctrl_first_q[`WGM_LO_HI:`WGM_LO_LO]};

	always_comb
	begin
		kind = KIND_NORMAL;
		upd = UPD_NOW;
		ovf = OVF_MAX;
		top_value = `CNT_MAX;
		case (waveform_mode_code)
			4'd1: begin kind = KIND_DUAL; upd = UPD_TOP; ovf = OVF_BOTTOM; top_value = `TOP_8BIT; end
			4'd2: begin kind = KIND_DUAL; upd = UPD_TOP; ovf = OVF_BOTTOM; top_value = `TOP_9BIT; end
			4'd3: begin kind = KIND_DUAL; upd = UPD_TOP; ovf = OVF_BOTTOM; top_value = `TOP_10BIT; end
			4'd4: begin kind = KIND_CTC; top_value = cmp_act_a_q; end
			4'd5: begin kind = KIND_FAST; upd = UPD_BOTTOM; ovf = OVF_TOP; top_value = `TOP_8BIT; end
			4'd6: begin kind = KIND_FAST; upd = UPD_BOTTOM; ovf = OVF_TOP; top_value = `TOP_9BIT; end
			4'd7: begin kind = KIND_FAST; upd = UPD_BOTTOM; ovf = OVF_TOP; top_value = `TOP_10BIT; end
			4'd8: begin kind = KIND_DUAL; upd = UPD_BOTTOM; ovf = OVF_BOTTOM; top_value = capture_q; end
			4'd9: begin kind = KIND_DUAL; upd = UPD_BOTTOM; ovf = OVF_BOTTOM; top_value = cmp_act_a_q; end
			4'd10: begin kind = KIND_DUAL; upd = UPD_TOP; ovf = OVF_BOTTOM; top_value = capture_q; end
			4'd11: begin kind = KIND_DUAL; upd = UPD_TOP; ovf = OVF_BOTTOM; top_value = cmp_act_a_q; end
			4'd12: begin kind = KIND_CTC; top_value = capture_q; end
			4'd14: begin kind = KIND_FAST; upd = UPD_BOTTOM; ovf = OVF_TOP; top_value = capture_q; end
			4'd15: begin kind = KIND_FAST; upd = UPD_BOTTOM; ovf = OVF_TOP; top_value = cmp_act_a_q; end
			default: kind = KIND_NORMAL;
		endcase
	end

	// Toggle on value 1 is a channel A privilege in the PWM kinds
	always_comb
	begin
		case (kind)
			KIND_FAST: tog_ok_a = (waveform_mode_code == 4'd14) || (waveform_mode_code == 4'd15);
			KIND_DUAL: tog_ok_a = (waveform_mode_code == 4'd9) || (waveform_mode_code == 4'd11);
			default: tog_ok_a = 1'b1;
		endcase
	end

	assign tog_ok_b = (kind == KIND_NORMAL) || (kind == KIND_CTC);

	assign at_top = (counter_q == top_value);
	assign at_bottom = (counter_q == `CNT_BOTTOM);

	// Counter; a TOP below the count lets it run through MAX before it meets TOP again
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			counter_q <= `CNT_RST;
			dir_q <= DIR_UP;
		end
		else if (tick_en)
		begin
			case (dir_q)
				DIR_UP:
				begin
					if (at_top && kind == KIND_DUAL && !at_bottom)
					begin
						counter_q <= counter_q - 16'h0001;
						dir_q <= DIR_DOWN;
					end
					else if (at_top)
						counter_q <= `CNT_BOTTOM;
					else
						counter_q <= counter_q + 16'h0001;
				end
				DIR_DOWN:
				begin
					if (kind != KIND_DUAL || at_bottom)
					begin
						counter_q <= counter_q + 16'h0001;
						dir_q <= DIR_UP;
					end
					else
						counter_q <= counter_q - 16'h0001;
				end
				default: dir_q <= DIR_UP;
			endcase
		end
	end

	// Double-buffered compare values
	always_comb
	begin
		case (upd)
			UPD_TOP: do_update = tick_en && at_top;
			UPD_BOTTOM: do_update = tick_en && at_bottom;
			default: do_update = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_act_a_q <= `CNT_RST;
			cmp_act_b_q <= `CNT_RST;
		end
		else if (do_update)
		begin
			cmp_act_a_q <= cmp_buf_a_q;
			cmp_act_b_q <= cmp_buf_b_q;
		end
	end

	// Sticky flags; a set in the same cycle as a clear wins
	assign set_ev[`ST_MATCH_A] = tick_en && (counter_q == cmp_act_a_q);
	assign set_ev[`ST_MATCH_B] = tick_en && (counter_q == cmp_act_b_q);
	assign set_ev[`ST_OVERFLOW] = tick_en && ((ovf == OVF_MAX && counter_q == `CNT_MAX) ||
		(ovf == OVF_TOP && at_top) || (ovf == OVF_BOTTOM && at_bottom));
	assign clr_ev = (wr_en && idx == `IDX_INT_CLEAR && hit) ? pwdata[2:0] : 3'b000;
	assign status_d = (status_q & ~clr_ev) | set_ev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= `INT_RST;
		else
			status_q <= status_d;
	end

	assign irq = |(status_q & int_en_q);

	// One unit per channel; only channel A may earn the value-1 toggle in the PWM kinds
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		wave_channel u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.tick_en(tick_en),
			.kind(kind),
			.out_mode((ch == 0) ? channel_a_output_mode : channel_b_output_mode),
			.toggle_ok((ch == 0) ? tog_ok_a : tog_ok_b),
			.counting_up(dir_q == DIR_UP),
			.counter_value(counter_q),
			.compare_value((ch == 0) ? cmp_act_a_q : cmp_act_b_q),
			.top_value(top_value),
			.wave_level(ch_level[ch]),
			.connected(ch_conn[ch])
		);
	end

	// Pins: waveform overrides port value, direction bit alone enables the driver
	assign channel_a_wave_out = ch_conn[0] ? ch_level[0] : port_q[`PORT_A_VAL];
	assign channel_b_wave_out = ch_conn[1] ? ch_level[1] : port_q[`PORT_B_VAL];
	assign channel_a_wave_oe = port_q[`PORT_A_DIR];
	assign channel_b_wave_oe = port_q[`PORT_B_DIR];

	AST_TICK_GATES_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
		!tick_en |=> counter_q == $past(counter_q))
		else $error("counter moved without tick");
	AST_PFC_BOTTOM_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
		(waveform_mode_code == 4'd8 || waveform_mode_code == 4'd9) && tick_en && at_top &&
		!at_bottom |=> cmp_act_b_q == $past(cmp_act_b_q))
		else $error("pfc compare updated at top");
	AST_BOTTOM_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_DUAL && tick_en && at_bottom |=> status_q[`ST_OVERFLOW])
		else $error("overflow flag not raised at bottom");
	AST_CTRL_UNUSED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && idx == `IDX_CTRL_FIRST && hit |=> ctrl_first_q[3:2] == 2'b00 &&
		ctrl_first_q[7:4] == $past(pwdata[7:4]))
		else $error("first control write wrong");
	AST_PIN_FOLLOWS_WAVE: assert property (@(posedge pclk) disable iff (!presetn)
		ch_conn[0] |-> channel_a_wave_out == ch_level[0])
		else $error("pin A not overridden");
	AST_OE_IS_DIRECTION: assert property (@(posedge pclk) disable iff (!presetn)
		channel_b_wave_oe == port_q[`PORT_B_DIR])
		else $error("pin B driver enable wrong");
	AST_FAST_TOGGLE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_FAST && channel_a_output_mode == 2'b01 && waveform_mode_code < 4'd14
		|-> !ch_conn[0] && channel_a_wave_out == port_q[`PORT_A_VAL])
		else $error("fast toggle connected in wrong mode");
	AST_DUAL_TOGGLE_B_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		kind == KIND_DUAL && channel_b_output_mode == 2'b01 |-> !ch_conn[1])
		else $error("channel B toggle connected in dual slope");
	AST_MODE_TOP_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
		waveform_mode_code == 4'd14 |-> top_value == capture_q && kind == KIND_FAST)
		else $error("mode 14 decode wrong");

endmodule

// File: dv/port_pins.sv
// Model of the two port pins that the compare outputs reach.
// Assumes out and enable come from the timer on pclk; the pins have no pull.
`timescale 1ns/10ps

module port_pins
(
	input wire logic pclk, // Clock
	input wire logic a_out, // Level for pin A
	input wire logic a_oe, // Driver enable A
	input wire logic b_out, // Level for pin B
	input wire logic b_oe, // Driver enable B
	output logic pin_a, // Pin A
	output logic pin_b // Pin B
);
	logic float_q;

	// An undriven pin must not look steady, so it follows a changing level
	always @(posedge pclk)
	begin
		float_q <= (float_q === 1'b1) ? 1'b0 : 1'b1;
	end

	assign pin_a = a_oe ? a_out : float_q;
	assign pin_b = b_oe ? b_out : float_q;
endmodule

// File: dv/compare_output_waveform_control_tb_top.sv
// Self-checking bench for the two-channel compare-output timer.
// Assumes a zero-wait APB slave; pins are read through the port_pins model.
`timescale 1ns/10ps
`include "tmr_cfg.svh"

module compare_output_waveform_control_tb_top
	import tmr_pkg::*;
;
	localparam logic [11:0] A_FIRST = 12'(`IDX_CTRL_FIRST * 4);
	localparam logic [11:0] A_SECOND = 12'(`IDX_CTRL_SECOND * 4);
	localparam logic [11:0] A_TICK = 12'(`IDX_TICK_CTRL * 4);
	localparam logic [11:0] A_CNT = 12'(`IDX_COUNTER * 4);
	localparam logic [11:0] A_CAP = 12'(`IDX_CAPTURE * 4);
	localparam logic [11:0] A_CMPA = 12'(`IDX_CMP_A * 4);
	localparam logic [11:0] A_CMPB = 12'(`IDX_CMP_B * 4);
	localparam logic [11:0] A_PORT = 12'(`IDX_PORT * 4);
	localparam logic [11:0] A_ST = 12'(`IDX_INT_STATUS * 4);
	localparam logic [11:0] A_EN = 12'(`IDX_INT_ENABLE * 4);
	localparam logic [11:0] A_CLR = 12'(`IDX_INT_CLEAR * 4);
	// Whole run needs about 8k cycles
	localparam int LIMIT = 40000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic a_out, a_oe, b_out, b_oe, irq, pin_a, pin_b;
	int mismatches, total_checks, cycles, ha, hb;

	timer_wave_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_a_wave_out(a_out), .channel_a_wave_oe(a_oe),
		.channel_b_wave_out(b_out), .channel_b_wave_oe(b_oe), .irq(irq));

	port_pins pins (.pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.pin_a(pin_a), .pin_b(pin_b));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			mismatches++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; read data and error are taken at the completing edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic set_mode(input logic [3:0] code, input logic [1:0] ma, input logic [1:0] mb);
		apb(A_SECOND, 1'b1, {27'h0, code[3:2], 3'h0});
		apb(A_FIRST, 1'b1, {24'h0, ma, mb, 2'h0, code[1:0]});
	endtask

	task automatic measure(input int n);
		ha = 0;
		hb = 0;
		repeat (n)
		begin
			@(negedge pclk);
			if (pin_a === 1'b1)
				ha++;
			if (pin_b === 1'b1)
				hb++;
		end
	endtask

	task automatic t_regs();
		check("latch_a", a_out, 0);
		check("latch_b", b_out, 0);
		check("oe_a", a_oe, 0);
		apb(A_FIRST, 1'b0, 32'h0);
		check("first_reset", rd, 0);
		apb(A_FIRST, 1'b1, 32'h0000_00FF);
		apb(A_FIRST, 1'b0, 32'h0);
		check("first_rw", rd, 32'h0000_00F3);
		apb(A_FIRST, 1'b1, 32'h0);
		apb(12'h3FC, 1'b0, 32'h0);
		check("unmapped_err", err, 1);
		$display("test regs done");
	endtask

	task automatic t_nonpwm();
		apb(A_CMPA, 1'b1, 32'h0000_0009);
		apb(A_CMPB, 1'b1, 32'h0000_0004);
		apb(A_PORT, 1'b1, 32'h0000_000E);
		set_mode(4'h4, 2'h0, 2'h0);
		apb(A_TICK, 1'b1, 32'h0000_0100);
		measure(40);
		check("port_a", ha, 0);
		check("port_b", hb, 40);
		check("oe_a_on", a_oe, 1);
		set_mode(4'h4, 2'h1, 2'h1);
		repeat (25) @(posedge pclk);
		measure(200);
		check("toggle_a", ha, 100);
		check("toggle_b", hb, 100);
		set_mode(4'h4, 2'h3, 2'h2);
		repeat (12) @(posedge pclk);
		measure(20);
		check("set_a", ha, 20);
		check("clr_b", hb, 0);
		apb(A_PORT, 1'b1, 32'h0);
		@(negedge pclk);
		check("oe_off_a", a_oe, 0);
		check("oe_off_b", b_oe, 0);
		apb(A_PORT, 1'b1, 32'h0000_000E);
		$display("test nonpwm done");
	endtask

	task automatic t_fast();
		set_mode(4'h5, 2'h2, 2'h3);
		apb(A_CMPA, 1'b1, 32'h0000_0040);
		apb(A_CMPB, 1'b1, 32'h0000_0040);
		repeat (600) @(posedge pclk);
		measure(512);
		check("fast_noninv", ha, 128);
		check("fast_inv", hb, 384);
		apb(A_CMPA, 1'b1, 32'h0000_00FF);
		apb(A_CMPB, 1'b1, 32'h0);
		repeat (600) @(posedge pclk);
		measure(512);
		check("fast_top_a", ha, 512);
		check("fast_zero_b", hb, 512);
		set_mode(4'h5, 2'h1, 2'h1);
		repeat (2) @(posedge pclk);
		measure(64);
		check("fast_off_a", ha, 0);
		check("fast_off_b", hb, 64);
		apb(A_CMPA, 1'b1, 32'h0000_007F);
		repeat (600) @(posedge pclk);
		// A smaller TOP is only safe while the count is still below it
		do
			apb(A_CNT, 1'b0, 32'h0);
		while (rd[15:0] > 16'h0020);
		set_mode(4'hF, 2'h1, 2'h1);
		repeat (300) @(posedge pclk);
		measure(512);
		check("fast_tgl_a", ha, 256);
		check("fast_tgl_b", hb, 512);
		$display("test fast done");
	endtask

	task automatic t_dual();
		set_mode(4'h9, 2'h1, 2'h1);
		repeat (300) @(posedge pclk);
		measure(508);
		check("dual_tgl_a", ha >= 250 && ha <= 258, 1);
		check("dual_tgl_b", hb, 508);
		apb(A_CAP, 1'b1, 32'h0000_007F);
		set_mode(4'h8, 2'h2, 2'h3);
		apb(A_CMPA, 1'b1, 32'h0000_0020);
		apb(A_CMPB, 1'b1, 32'h0000_0020);
		repeat (600) @(posedge pclk);
		measure(508);
		check("dual_noninv", ha >= 124 && ha <= 132, 1);
		check("dual_sum", ha + hb, 508);
		apb(A_CMPA, 1'b1, 32'h0);
		apb(A_CMPB, 1'b1, 32'h0000_007F);
		set_mode(4'h8, 2'h2, 2'h2);
		repeat (600) @(posedge pclk);
		measure(508);
		check("dual_bottom", ha, 0);
		check("dual_top", hb, 508);
		$display("test dual done");
	endtask

	task automatic t_irq();
		apb(A_ST, 1'b0, 32'h0);
		check("ovf_flag", rd[2], 1);
		apb(A_EN, 1'b1, 32'h0000_0004);
		repeat (2) @(posedge pclk);
		check("irq_on", irq, 1);
		apb(A_EN, 1'b1, 32'h0);
		repeat (2) @(posedge pclk);
		check("irq_masked", irq, 0);
		apb(A_TICK, 1'b1, 32'h0);
		apb(A_CLR, 1'b1, 32'h0000_0007);
		apb(A_EN, 1'b1, 32'h0000_0004);
		repeat (300) @(posedge pclk);
		apb(A_ST, 1'b0, 32'h0);
		check("no_tick_flags", rd, 0);
		check("irq_cleared", irq, 0);
		$display("test irq done");
	endtask

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_nonpwm();
		t_fast();
		t_dual();
		t_irq();
		summarize();
	end
endmodule
